// file: design/portc_edge_change_detect.sv
`timescale 1ns/100ps
module portc_edge_change_detect #(
  parameter int PINS = portc_ioc_pkg::PIN_COUNT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [5:0] portc_pin,
  input wire logic [5:0] porta_change_flag,
  output logic change_int_flag,
  output logic change_irq
);
  // enabled edges for one set of samples
  function automatic logic [5:0] edge_hits(input logic [5:0] now_s, input logic [5:0] old_s,
                                           input logic [5:0] rise_en, input logic [5:0] fall_en);
    edge_hits = (now_s & ~old_s & rise_en) | (~now_s & old_s & fall_en);
  endfunction

  function automatic logic [31:0] pad6(input logic [5:0] v);
    pad6 = {26'h000_0000, v};
  endfunction

  // bus side state
  portc_ioc_pkg::addr_phase_type ap_q;
  portc_ioc_pkg::addr_phase_type ap_d;
  logic [31:0] hrdata_d;

  // software registers
  logic [5:0] portc_rise_enable_q;
  logic [5:0] portc_rise_enable_d;
  logic [5:0] portc_fall_enable_q;
  logic [5:0] portc_fall_enable_d;
  logic [5:0] portc_change_flag_q;
  logic [5:0] portc_change_flag_d;
  logic change_int_enable_q;
  logic change_int_enable_d;
  logic [1:0] int_status_q;
  logic [1:0] int_status_d;
  logic [1:0] int_mask_q;
  logic [1:0] int_mask_d;

  // pin sampling
  logic [5:0] sync_pin;
  logic [5:0] prev_q;
  logic [2:0] warm_q;
  logic primed;
  portc_ioc_pkg::pin_edge_type seen;
  logic [5:0] edge_hit;

  logic change_int_flag_d;
  logic change_irq_d;

  // address phase
  wire addr_ok = hsel && hready && (htrans == portc_ioc_pkg::HTRANS_NONSEQ || htrans[1]);
  wire [7:0] rd_ofs = haddr[7:0];
  wire hi_zero = (haddr[31:8] == 24'h00_0000);

  // data phase write strobes
  wire wr_any = ap_q.valid && ap_q.write;
  wire wr_rise = wr_any && (ap_q.offset == portc_ioc_pkg::OFS_RISE);
  wire wr_fall = wr_any && (ap_q.offset == portc_ioc_pkg::OFS_FALL);
  wire wr_flag = wr_any && (ap_q.offset == portc_ioc_pkg::OFS_FLAG);
  wire wr_core = wr_any && (ap_q.offset == portc_ioc_pkg::OFS_CORE);
  wire wr_status = wr_any && (ap_q.offset == portc_ioc_pkg::OFS_STATUS);
  wire wr_mask = wr_any && (ap_q.offset == portc_ioc_pkg::OFS_MASK);
  wire [5:0] wdata6 = hwdata[5:0];
  wire [1:0] wdata2 = hwdata[1:0];

  // read mux; unmapped reads give zero
  wire [31:0] core_word = {28'h000_0000, change_int_enable_q, 2'h0, change_int_flag};
  wire [31:0] stat_word = {30'h0000_0000, int_status_q};
  wire [31:0] mask_word = {30'h0000_0000, int_mask_q};
  wire [31:0] read_word =
    !hi_zero ? 32'h0000_0000 :
    (rd_ofs == portc_ioc_pkg::OFS_RISE) ? pad6(portc_rise_enable_q) :
    (rd_ofs == portc_ioc_pkg::OFS_FALL) ? pad6(portc_fall_enable_q) :
    (rd_ofs == portc_ioc_pkg::OFS_FLAG) ? pad6(portc_change_flag_q) :
    (rd_ofs == portc_ioc_pkg::OFS_CORE) ? core_word :
    (rd_ofs == portc_ioc_pkg::OFS_STATUS) ? stat_word :
    (rd_ofs == portc_ioc_pkg::OFS_MASK) ? mask_word :
    32'h0000_0000;

  assign ap_d = '{valid: addr_ok && hi_zero, write: hwrite, offset: haddr[7:0]};
  assign hrdata_d = (addr_ok && !hwrite) ? read_word : hrdata;

  pin_sync #(
    .WIDTH(6)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .d(portc_pin),
    .q(sync_pin)
  );

  // sync and previous stage start at zero; hold off until both carry real samples
  assign primed = warm_q[portc_ioc_pkg::WARM_W-1];
  assign seen = '{rise: sync_pin & ~prev_q, fall: ~sync_pin & prev_q};
  assign edge_hit = primed ?
    edge_hits(sync_pin, prev_q, portc_rise_enable_q, portc_fall_enable_q) : 6'h00;

  // register next values
  assign portc_rise_enable_d = wr_rise ? wdata6 : portc_rise_enable_q;
  assign portc_fall_enable_d = wr_fall ? wdata6 : portc_fall_enable_q;
  // written value first, then hardware set on top so an edge never gets lost
  assign portc_change_flag_d = (wr_flag ? wdata6 : portc_change_flag_q) | edge_hit;
  assign change_int_enable_d = wr_core ? hwdata[portc_ioc_pkg::CORE_ENABLE_POS] : change_int_enable_q;
  assign int_mask_d = wr_mask ? wdata2 : int_mask_q;

  wire ev_edge = |edge_hit;
  wire ev_clash = wr_flag && |(edge_hit & ~wdata6);
  wire [1:0] events = {ev_clash, ev_edge};
  assign int_status_d = (wr_status ? (int_status_q & ~wdata2) : int_status_q) | events;

  // combined flag follows the flags, also the companion port's
  assign change_int_flag_d = (|portc_change_flag_d) || (|porta_change_flag);
  assign change_irq_d = change_int_enable_q && |(int_status_q & int_mask_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= '0;
      hrdata <= portc_ioc_pkg::RST_RDATA;
      hreadyout <= 1'b1;
      hresp <= portc_ioc_pkg::HRESP_OKAY;
    end else if (ce) begin
      ap_q <= ap_d;
      hrdata <= hrdata_d;
      hreadyout <= 1'b1;
      hresp <= portc_ioc_pkg::HRESP_OKAY;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      portc_rise_enable_q <= portc_ioc_pkg::RST_PINS;
      portc_fall_enable_q <= portc_ioc_pkg::RST_PINS;
      portc_change_flag_q <= portc_ioc_pkg::RST_PINS;
      change_int_enable_q <= portc_ioc_pkg::RST_ENABLE;
    end else if (ce) begin
      portc_rise_enable_q <= portc_rise_enable_d;
      portc_fall_enable_q <= portc_fall_enable_d;
      portc_change_flag_q <= portc_change_flag_d;
      change_int_enable_q <= change_int_enable_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_status_q <= portc_ioc_pkg::RST_STAT;
      int_mask_q <= portc_ioc_pkg::RST_STAT;
      change_int_flag <= 1'b0;
      change_irq <= 1'b0;
    end else if (ce) begin
      int_status_q <= int_status_d;
      int_mask_q <= int_mask_d;
      change_int_flag <= change_int_flag_d;
      change_irq <= change_irq_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= portc_ioc_pkg::RST_PINS;
      warm_q <= portc_ioc_pkg::RST_WARM;
    end else if (ce) begin
      prev_q <= sync_pin;
      warm_q <= {warm_q[1:0], 1'b1};
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  wire [5:0] fall_hit = seen.fall & portc_fall_enable_q;
  wire [5:0] rise_hit = seen.rise & portc_rise_enable_q;
  wire [5:0] both_en = portc_rise_enable_q & portc_fall_enable_q;
  wire rd_narrow = addr_ok && !hwrite && hi_zero &&
                   (rd_ofs == portc_ioc_pkg::OFS_FALL || rd_ofs == portc_ioc_pkg::OFS_FLAG);
  wire rd_take = addr_ok && !hwrite;

  a_fall_sets_flag: assert property (
    (ce && primed && |fall_hit) |=> &(portc_change_flag_q | ~$past(fall_hit))
  ) else $error("enabled falling edge did not set its flag");

  a_rise_sets_flag: assert property (
    (ce && primed && |rise_hit) |=> &(portc_change_flag_q | ~$past(rise_hit))
  ) else $error("enabled rising edge did not set its flag");

  a_masked_no_set: assert property (
    (ce && !wr_flag && (seen.fall & ~portc_fall_enable_q) != 6'h00 && rise_hit == 6'h00 &&
     fall_hit == 6'h00) |=> portc_change_flag_q == $past(portc_change_flag_q)
  ) else $error("disabled falling edge changed a flag");

  a_both_dirs: assert property (
    (ce && primed && |((seen.rise | seen.fall) & both_en)) |=>
      &(portc_change_flag_q | ~$past((seen.rise | seen.fall) & both_en))
  ) else $error("pin with both enables missed an edge");

  a_write_clears: assert property (
    (ce && wr_flag && edge_hit == 6'h00) |=> portc_change_flag_q == $past(wdata6)
  ) else $error("flag write did not store the written value");

  a_set_beats_clear: assert property (
    (ce && wr_flag && |edge_hit) |=> &(portc_change_flag_q | ~$past(edge_hit))
  ) else $error("edge during flag clear was lost");

  a_upper_read_zero: assert property (
    (ce && rd_narrow) |=> hrdata[31:6] == 26'h000_0000
  ) else $error("unimplemented bits read nonzero");

  a_combined_flag: assert property (
    ce |=> change_int_flag == ((|portc_change_flag_q) || (|$past(porta_change_flag)))
  ) else $error("combined change flag does not match the pin flags");

  a_irq_gated: assert property (
    (ce && !change_int_enable_q) |=> !change_irq
  ) else $error("interrupt raised with change interrupt disabled");

  a_sync_two_stage: assert property (
    ($past(ce) && $past(ce, 2) && $past(hresetn) && $past(hresetn, 2)) |->
      sync_pin == $past(portc_pin, 2)
  ) else $error("pin sample is not two cycles behind the pin");

  a_reset_clear: assert property (
    @(posedge hclk) disable iff (1'b0)
    !hresetn |-> (portc_change_flag_q == 6'h00 && portc_fall_enable_q == 6'h00 &&
                  portc_rise_enable_q == 6'h00 && !change_int_enable_q)
  ) else $error("enable or flag not zero in reset");

  a_rise_en_write: assert property (
    (ce && wr_rise) |=> portc_rise_enable_q == $past(wdata6)
  ) else $error("rise enable write did not land");

  a_fall_en_write: assert property (
    (ce && wr_fall) |=> portc_fall_enable_q == $past(wdata6)
  ) else $error("fall enable write did not land");

  a_rise_en_hold: assert property (
    (!ce || !wr_rise) |=> $stable(portc_rise_enable_q)
  ) else $error("rise enable changed without a write");

  a_fall_en_hold: assert property (
    (!ce || !wr_fall) |=> $stable(portc_fall_enable_q)
  ) else $error("fall enable changed without a write");

  a_flag_sticky: assert property (
    (ce && !wr_flag && edge_hit == 6'h00) |=> $stable(portc_change_flag_q)
  ) else $error("flag changed with no edge and no write");

  a_flag_only_hits: assert property (
    (ce && !wr_flag) |=>
      (portc_change_flag_q & ~$past(portc_change_flag_q) & ~$past(edge_hit)) == 6'h00
  ) else $error("flag set without an enabled edge");

  a_edge_needs_change: assert property (
    (edge_hit & ~(sync_pin ^ prev_q)) == 6'h00
  ) else $error("edge reported on a pin whose sample did not change");

  a_prev_follows: assert property (
    ce |=> prev_q == $past(sync_pin)
  ) else $error("previous sample does not follow the synchronised pin");

  a_flag_to_combined: assert property (
    (ce && |edge_hit) |=> change_int_flag
  ) else $error("enabled edge did not raise the combined flag");

  a_status_edge: assert property (
    (ce && |edge_hit) |=> int_status_q[portc_ioc_pkg::STAT_EDGE_POS]
  ) else $error("enabled edge did not set the edge status bit");

  a_status_clash: assert property (
    (ce && ev_clash) |=> int_status_q[portc_ioc_pkg::STAT_CLASH_POS]
  ) else $error("edge during a flag write did not set the clash status bit");

  a_status_w1c: assert property (
    (ce && wr_status && events == 2'h0) |=>
      int_status_q == ($past(int_status_q) & ~$past(wdata2))
  ) else $error("status write one to clear misbehaved");

  a_status_hold: assert property (
    (ce && !wr_status && events == 2'h0) |=> $stable(int_status_q)
  ) else $error("status changed with no event and no write");

  a_mask_write: assert property (
    (ce && wr_mask) |=> int_mask_q == $past(wdata2)
  ) else $error("mask write did not land");

  a_enable_write: assert property (
    (ce && wr_core) |=>
      change_int_enable_q == $past(hwdata[portc_ioc_pkg::CORE_ENABLE_POS])
  ) else $error("change interrupt enable write did not land");

  a_irq_follows: assert property (
    ce |=> change_irq ==
      ($past(change_int_enable_q) && |($past(int_status_q) & $past(int_mask_q)))
  ) else $error("interrupt output does not follow enable, status and mask");

  a_read_rise: assert property (
    (ce && rd_take && hi_zero && rd_ofs == portc_ioc_pkg::OFS_RISE) |=>
      hrdata == pad6($past(portc_rise_enable_q))
  ) else $error("rise enable read back wrong");

  a_read_fall: assert property (
    (ce && rd_take && hi_zero && rd_ofs == portc_ioc_pkg::OFS_FALL) |=>
      hrdata == pad6($past(portc_fall_enable_q))
  ) else $error("fall enable read back wrong");

  a_read_flag: assert property (
    (ce && rd_take && hi_zero && rd_ofs == portc_ioc_pkg::OFS_FLAG) |=>
      hrdata == pad6($past(portc_change_flag_q))
  ) else $error("change flags read back wrong");

  a_read_unmapped: assert property (
    (ce && rd_take && !hi_zero) |=> hrdata == 32'h0000_0000
  ) else $error("read outside the decoded range was not zero");

  a_hrdata_hold: assert property (
    !(ce && rd_take) |=> $stable(hrdata)
  ) else $error("read data moved without a read");

  a_bus_okay: assert property (
    hreadyout && hresp == portc_ioc_pkg::HRESP_OKAY
  ) else $error("bus stalled or answered with an error");

  a_ce_freeze: assert property (
    !ce |=> $stable(portc_change_flag_q) && $stable(int_status_q) &&
      $stable(prev_q) && $stable(sync_pin)
  ) else $error("state moved while the clock enable was low");

  a_ce_freeze_out: assert property (
    !ce |=> $stable(change_int_flag) && $stable(change_irq) &&
      $stable(hrdata)
  ) else $error("outputs moved while the clock enable was low");

  c_rise_flag: cover property (ce && primed && |rise_hit ##1 |portc_change_flag_q);
  c_fall_flag: cover property (ce && primed && |fall_hit ##1 |portc_change_flag_q);
  c_clash: cover property (ce && ev_clash);
  c_irq: cover property (ce && change_int_enable_q && |int_mask_q ##[1:20] change_irq);
endmodule

// file: pkg/portc_ioc_pkg.sv
// Overview of operation
// - with fall enable set, a high-to-low pin transition counts as a change
// - an enabled edge sets the pin flag and the combined change flag
// - with fall enable clear, falling edges on that pin are ignored
// - rise enable set and a low-to-high transition sets the pin flag
// - fall enable set and a high-to-low transition sets the pin flag
// - a zero flag means no change since clear; writing zero clears it
// - flags are set by hardware, software may read and write bits 5 to 0
// - bits 7 and 6 of fall enable and flag registers read as zero
// - every enable and flag bit resets to zero on any reset
// - combined change flag is the OR of all pin flags of both ports
// - an interrupt request is raised only while change interrupt enable is set
// - an edge during a flag write leaves that flag set whatever is written
// - both enables set on a pin detects transitions in both directions
package portc_ioc_pkg;
  localparam int PIN_COUNT = 6;
  localparam int DATA_W = 32;
  localparam int DEC_W = 8;
  localparam int SYNC_STAGES = 2;
  localparam int WARM_W = 3;

  localparam logic [7:0] OFS_RISE = 8'h00;
  localparam logic [7:0] OFS_FALL = 8'h04;
  localparam logic [7:0] OFS_FLAG = 8'h08;
  localparam logic [7:0] OFS_CORE = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;

  localparam int CORE_FLAG_POS = 0;
  localparam int CORE_ENABLE_POS = 3;
  localparam int STAT_W = 2;
  localparam int STAT_EDGE_POS = 0;
  localparam int STAT_CLASH_POS = 1;

  localparam logic [5:0] RST_PINS = 6'h00;
  localparam logic RST_ENABLE = 1'b0;
  localparam logic [1:0] RST_STAT = 2'h0;
  localparam logic [2:0] RST_WARM = 3'h0;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] offset;
  } addr_phase_type;

  typedef struct packed {
    logic [5:0] rise;
    logic [5:0] fall;
  } pin_edge_type;
endpackage

// file: design/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 6
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // first stage feeds only the second stage
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      q <= '0;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// file: tb/portc_edge_change_detect_tb.sv
`timescale 1ns/100ps
module portc_edge_change_detect_tb;
  localparam logic [31:0] adr [6] = '{
    {24'h0, portc_ioc_pkg::OFS_RISE}, {24'h0, portc_ioc_pkg::OFS_FALL},
    {24'h0, portc_ioc_pkg::OFS_FLAG}, {24'h0, portc_ioc_pkg::OFS_CORE},
    {24'h0, portc_ioc_pkg::OFS_STATUS}, {24'h0, portc_ioc_pkg::OFS_MASK}};
  logic hclk = 1'b0;
  // starts unknown so the first drive low is a real falling edge
  logic hresetn;
  logic ce = 1'b1;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic change_int_flag;
  logic change_irq;
  logic [31:0] hrdata;
  logic [5:0] portc_pin = 6'h00;
  logic [5:0] porta_change_flag = 6'h00;
  logic [31:0] seed = 32'h0000_04ad;
  logic [31:0] rd;
  int n_fail = 0;
  int compares = 0;

  always #5 hclk = ~hclk;

  portc_edge_change_detect i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .portc_pin(portc_pin), .porta_change_flag(porta_change_flag),
    .change_int_flag(change_int_flag), .change_irq(change_irq));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [5:0] edges(input logic [5:0] r, f, o, n);
    return (r & ~o & n) | (f & o & ~n);
  endfunction

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // caller sits just after a rising edge; waits only on hready, the watchdog bounds it
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    haddr <= a;
    hwrite <= wr;
    htrans <= portc_ioc_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk_word(rd, exp);
    chk_bit(hresp, portc_ioc_pkg::HRESP_OKAY);
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask

  task automatic reset_chk();
    chk_bit(change_int_flag, 1'b0);
    chk_bit(change_irq, 1'b0);
    for (int i = 0; i < 6; i++) rd_chk(adr[i], 32'h0);
  endtask

  task automatic wrap_up();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    wrap_up();
  end

  initial begin
    logic [5:0] r, f, nv, ef, pa;
    logic [31:0] w;
    logic en;
    logic [1:0] m;
    do_reset();
    reset_chk();
    for (int i = 0; i < 3; i++) begin
      w = rnd();
      bus(1'b1, adr[i], w);
      rd_chk(adr[i], {26'h0, w[5:0]});
    end
    bus(1'b1, adr[2], 32'h0);
    bus(1'b1, 32'h18, rnd());
    rd_chk(32'h18, 32'h0);
    rd_chk(32'h100 | adr[0], 32'h0);
    for (int k = 0; k < 40; k++) begin
      r = 6'(rnd());
      f = 6'(rnd());
      // first pass both directions on every pin, second pass nothing enabled
      if (k < 2) begin
        r = {6{k == 0}};
        f = r;
      end
      w = rnd();
      en = w[0];
      m = w[2:1];
      nv = w[13:8];
      pa = (w[4:3] == 2'h0) ? w[21:16] : 6'h00;
      bus(1'b1, adr[0], {26'h0, r});
      bus(1'b1, adr[1], {26'h0, f});
      bus(1'b1, adr[3], {28'h0, en, 3'h0});
      bus(1'b1, adr[5], {30'h0, m});
      ef = edges(r, f, portc_pin, nv);
      portc_pin <= nv;
      porta_change_flag <= pa;
      repeat (5) @(posedge hclk);
      rd_chk(adr[2], {26'h0, ef});
      chk_bit(change_int_flag, |{ef, pa});
      rd_chk(adr[3], {28'h0, en, 2'h0, |{ef, pa}});
      rd_chk(adr[4], {31'h0, |ef});
      chk_bit(change_irq, en & m[0] & |ef);
      bus(1'b1, adr[2], 32'h0);
      bus(1'b1, adr[4], 32'h3);
      rd_chk(adr[2], 32'h0);
    end
    // clearing write lands on the same edge as a fresh edge on every pin
    bus(1'b1, adr[0], 32'h3f);
    bus(1'b1, adr[1], 32'h3f);
    bus(1'b1, adr[3], 32'h8);
    bus(1'b1, adr[5], 32'h2);
    nv = ~portc_pin;
    portc_pin <= nv;
    @(posedge hclk);
    bus(1'b1, adr[2], 32'h0);
    repeat (3) @(posedge hclk);
    rd_chk(adr[2], 32'h3f);
    rd_chk(adr[4], 32'h3);
    chk_bit(change_irq, 1'b1);
    // clock enable low freezes the pipeline, the pin change waits for it
    porta_change_flag <= 6'h00;
    bus(1'b1, adr[2], 32'h0);
    ce <= 1'b0;
    portc_pin <= ~nv;
    repeat (6) @(posedge hclk);
    chk_bit(change_int_flag, 1'b0);
    ce <= 1'b1;
    repeat (5) @(posedge hclk);
    chk_bit(change_int_flag, 1'b1);
    rd_chk(adr[2], 32'h3f);
    do_reset();
    reset_chk();
    wrap_up();
  end
endmodule
